// File: src/dcdp_pkg.sv
// shared constants and types of the converter channel data path
package dcdp_pkg;
	localparam int DCDP_NCH      = 16;
	localparam int DCDP_GRP_CH   = 8;
	localparam int DCDP_CH_AW    = 4;
	localparam int DCDP_MAXW     = 16;
	localparam int DCDP_SHIFT_W  = 14;
	localparam int DCDP_CTRL_W   = 5;
	localparam int DCDP_MON_W    = 6;
	localparam int DCDP_GPIO_W   = 2;
	// bank choice position inside control_bits
	localparam int DCDP_CTRL_BANK = 0;

	// reset values, high-resolution variant
	localparam logic [15:0] DCDP_RST_IN_16   = 16'h8000;
	localparam logic [15:0] DCDP_RST_GAIN_16 = 16'hFFFF;
	localparam logic [15:0] DCDP_RST_OFS_16  = 16'h8000;
	// reset values, reduced-resolution variant
	localparam logic [15:0] DCDP_RST_IN_14   = 16'h2000;
	localparam logic [15:0] DCDP_RST_GAIN_14 = 16'h3FFF;
	localparam logic [15:0] DCDP_RST_OFS_14  = 16'h2000;
	localparam logic [13:0] DCDP_RST_SHIFT   = 14'h2000;
	localparam logic [4:0]  DCDP_RST_CTRL    = 5'h00;
	localparam logic [5:0]  DCDP_RST_MON     = 6'h00;
	localparam logic [1:0]  DCDP_RST_GPIO    = 2'h0;
	localparam logic [7:0]  DCDP_RST_SEL     = 8'h00;

	// per-channel word kinds inside the channel store
	typedef enum logic [1:0] {
		DCDP_W_FIRST,
		DCDP_W_SECOND,
		DCDP_W_GAIN,
		DCDP_W_OFFSET
	} dcdp_word_t;

	// targets of a host write or read
	typedef enum logic [3:0] {
		DCDP_T_DATA,
		DCDP_T_GAIN,
		DCDP_T_OFFSET,
		DCDP_T_SHIFT0,
		DCDP_T_SHIFT1,
		DCDP_T_CTRL,
		DCDP_T_MON,
		DCDP_T_GPIO,
		DCDP_T_SEL0,
		DCDP_T_SEL1,
		DCDP_T_DATA_B
	} dcdp_target_t;

	typedef enum logic [1:0] {
		DCDP_S_IDLE,
		DCDP_S_FETCH,
		DCDP_S_CALC
	} dcdp_state_t;
endpackage

// File: src/dcdp_chan_store.sv
// per-channel input, gain and offset word storage with registered reads
`timescale 1ns/1ps
`default_nettype none
module dcdp_chan_store #(
	parameter int W   = 16,
	parameter int NCH = 16,
	parameter int AW  = 4,
	parameter logic [W-1:0] RST_IN   = '0,
	parameter logic [W-1:0] RST_GAIN = '0,
	parameter logic [W-1:0] RST_OFS  = '0
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	// write port
	input  wire logic                  wr_en,
	input  wire dcdp_pkg::dcdp_word_t  wr_word,
	input  wire logic [AW-1:0]         wr_chan,
	input  wire logic [W-1:0]          wr_data,
	// calculation read port, all words of one channel
	input  wire logic [AW-1:0]         calc_chan,
	output logic      [W-1:0]          calc_first_r,
	output logic      [W-1:0]          calc_second_r,
	output logic      [W-1:0]          calc_gain_r,
	output logic      [W-1:0]          calc_offset_r,
	// host read port
	input  wire logic [AW-1:0]         host_chan,
	input  wire dcdp_pkg::dcdp_word_t  host_word,
	output logic      [W-1:0]          host_data_r
);
	import dcdp_pkg::*;

	logic [W-1:0] first_r  [NCH];
	logic [W-1:0] second_r [NCH];
	logic [W-1:0] gain_r   [NCH];
	logic [W-1:0] offset_r [NCH];
	logic [W-1:0] host_sel;

	initial begin
		if (NCH > (1 << AW)) $error("channel count exceeds address width");
	end

	assign host_sel = (host_word == DCDP_W_FIRST)  ? first_r[host_chan]  :
	                  (host_word == DCDP_W_SECOND) ? second_r[host_chan] :
	                  (host_word == DCDP_W_GAIN)   ? gain_r[host_chan]   : offset_r[host_chan];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				first_r[i]  <= RST_IN;
				second_r[i] <= RST_IN;
				gain_r[i]   <= RST_GAIN;
				offset_r[i] <= RST_OFS;
			end
		end else if (wr_en) begin
			unique case (wr_word)
				DCDP_W_FIRST:  first_r[wr_chan]  <= wr_data;
				DCDP_W_SECOND: second_r[wr_chan] <= wr_data;
				DCDP_W_GAIN:   gain_r[wr_chan]   <= wr_data;
				DCDP_W_OFFSET: offset_r[wr_chan] <= wr_data;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			calc_first_r  <= RST_IN;
			calc_second_r <= RST_IN;
			calc_gain_r   <= RST_GAIN;
			calc_offset_r <= RST_OFS;
			host_data_r   <= '0;
		end else begin
			calc_first_r  <= first_r[calc_chan];
			calc_second_r <= second_r[calc_chan];
			calc_gain_r   <= gain_r[calc_chan];
			calc_offset_r <= offset_r[calc_chan];
			host_data_r   <= host_sel;
		end
	end
endmodule
`default_nettype wire

// File: src/dcdp_data_path.sv
// converter channel data path: storage, shared calibration, selection and load
//
// Overview of operation
// [RL1] sixteen channels in two groups of eight
// [RL2] channel words are 16 or 14 bits
// [RL3] seven data words held per channel
// [RL4] calibrated words hidden from host access
// [RL5] converter register loads only calibrated words
// [RL6] two 14-bit group shift registers
// [RL7] 5-bit control, 6-bit monitor, 2-bit pin setup
// [RL8] 16-bit reset: 0x8000 inputs/offset, 0xFFFF gain
// [RL9] 14-bit reset values; control, selects reset zero
// [RL10] data write targets word by bank bit
// [RL11] bank bit is global for all channels
// [RL12] calibrated word from matching input word
// [RL13] one shared multiplier-adder, channels in turn
// [RL14] first calibrated word recomputed on its writes
// [RL15] second calibrated word recomputed on its writes
// [RL16] per-group select bit picks calibrated word
// [RL17] global command sets all select bits
// [RL18] load low updates all converter registers
// [RL19] code = in*(gain+1)/2^W + offset - 2^(W-1)
// [RL20] host keeps result within code range
// [RL21] out-of-range result clamped to range end
// [RL22] while load low, registers follow recalculation
`timescale 1ns/1ps
`default_nettype none
module dcdp_data_path #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         sys_rst,
	// register write from the serial port decoder
	input  wire logic                         wr_valid,
	input  wire dcdp_pkg::dcdp_target_t       wr_target,
	input  wire logic [dcdp_pkg::DCDP_CH_AW-1:0] wr_chan,
	input  wire logic [W-1:0]                 wr_data,
	// register readback
	input  wire logic                         rd_valid,
	input  wire dcdp_pkg::dcdp_target_t       rd_target,
	input  wire logic [dcdp_pkg::DCDP_CH_AW-1:0] rd_chan,
	output logic      [W-1:0]                 rd_data_r,
	output logic                              rd_ack_r,
	// global select command
	input  wire logic                         sel_all_valid,
	input  wire logic                         sel_all_value,
	// load pin, asynchronous
	input  wire logic                         load_outputs_n,
	// converter codes and group settings
	output logic [dcdp_pkg::DCDP_NCH*W-1:0]   dac_code_r,
	output logic [dcdp_pkg::DCDP_SHIFT_W-1:0] group_zero_shift_r,
	output logic [dcdp_pkg::DCDP_SHIFT_W-1:0] group_one_shift_r,
	output logic [dcdp_pkg::DCDP_CTRL_W-1:0]  control_bits_r,
	output logic [dcdp_pkg::DCDP_MON_W-1:0]   monitor_setup_r,
	output logic [dcdp_pkg::DCDP_GPIO_W-1:0]  gpio_setup_r,
	output logic                              calc_busy_r
);
	import dcdp_pkg::*;

	localparam int NCH = DCDP_NCH;
	localparam int PW  = 2 * W + 1;
	localparam int SW  = W + 3;
	// [RL8] [RL9] reset words follow the resolution
	localparam logic [W-1:0] RST_IN   = (W == 16) ? DCDP_RST_IN_16[W-1:0]   : DCDP_RST_IN_14[W-1:0];
	localparam logic [W-1:0] RST_GAIN = (W == 16) ? DCDP_RST_GAIN_16[W-1:0] : DCDP_RST_GAIN_14[W-1:0];
	localparam logic [W-1:0] RST_OFS  = (W == 16) ? DCDP_RST_OFS_16[W-1:0]  : DCDP_RST_OFS_14[W-1:0];
	localparam logic signed [SW-1:0] HALF   = SW'(1) <<< (W - 1);
	localparam logic signed [SW-1:0] TOPVAL = (SW'(1) <<< W) - SW'(1);
	localparam logic [W:0] ONE_W1 = (W + 1)'(1);

	// [RL2] only the two documented resolutions
	initial begin
		if (W != 16 && W != 14) $error("resolution must be 16 or 14");
		if (NCH != 2 * DCDP_GRP_CH) $error("channel count must be two groups");
		if (NCH > (1 << DCDP_CH_AW)) $error("channel address too narrow");
	end

	// load pin synchroniser
	// only the second flop is read; the first may be metastable
	logic load_s1_r;
	logic load_s2_r;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			load_s1_r <= 1'b1;
			load_s2_r <= 1'b1;
		end else begin
			load_s1_r <= load_outputs_n;
			load_s2_r <= load_s1_r;
		end
	end

	// [RL10] [RL11] global bank bit steers data writes
	wire        bank_bit   = control_bits_r[DCDP_CTRL_BANK];
	wire        wr_data_t  = wr_valid && (wr_target == DCDP_T_DATA);
	wire        wr_gain_t  = wr_valid && (wr_target == DCDP_T_GAIN);
	wire        wr_ofs_t   = wr_valid && (wr_target == DCDP_T_OFFSET);
	wire        store_wr   = wr_data_t || wr_gain_t || wr_ofs_t;
	dcdp_word_t store_word;
	assign store_word = wr_gain_t ? DCDP_W_GAIN :
	                    wr_ofs_t  ? DCDP_W_OFFSET :
	                    bank_bit  ? DCDP_W_SECOND : DCDP_W_FIRST;

	// host read word mapping; data readback follows the bank bit too
	dcdp_word_t host_word;
	assign host_word = (rd_target == DCDP_T_GAIN)   ? DCDP_W_GAIN :
	                   (rd_target == DCDP_T_OFFSET) ? DCDP_W_OFFSET :
	                   (rd_target == DCDP_T_DATA_B) ? DCDP_W_SECOND :
	                   bank_bit                     ? DCDP_W_SECOND : DCDP_W_FIRST;

	// [RL14] [RL15] write marks the affected calibrated word stale
	wire [NCH-1:0] chan_hot    = store_wr ? (NCH'(1) << wr_chan) : '0;
	wire [NCH-1:0] set_first   = bank_bit ? '0 : chan_hot;
	wire [NCH-1:0] set_second  = bank_bit ? chan_hot : '0;

	// [RL13] single calculation slot picks lowest pending job
	// a job reads its words at fetch time, so a queued job sees later writes
	dcdp_state_t               state_r;
	logic [NCH-1:0]            pend_first_r;
	logic [NCH-1:0]            pend_second_r;
	logic [DCDP_CH_AW-1:0]     job_chan_r;
	logic                      job_bank_r;
	logic [DCDP_CH_AW-1:0]     pick_chan;
	logic                      pick_bank;
	logic                      pick_any;
	always_comb begin
		pick_chan = '0;
		pick_bank = 1'b0;
		pick_any  = 1'b0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pend_second_r[i]) begin
				pick_chan = DCDP_CH_AW'(i);
				pick_bank = 1'b1;
				pick_any  = 1'b1;
			end
			if (pend_first_r[i]) begin
				pick_chan = DCDP_CH_AW'(i);
				pick_bank = 1'b0;
				pick_any  = 1'b1;
			end
		end
	end
	// lowest channel wins; within it the first word goes first
	wire           take_job    = (state_r == DCDP_S_IDLE) && pick_any;
	wire [NCH-1:0] clr_hot     = take_job ? (NCH'(1) << pick_chan) : '0;
	wire [NCH-1:0] clr_first   = pick_bank ? '0 : clr_hot;
	wire [NCH-1:0] clr_second  = pick_bank ? clr_hot : '0;

	logic [W-1:0] c_first;
	logic [W-1:0] c_second;
	logic [W-1:0] c_gain;
	logic [W-1:0] c_offset;

	// [RL3] input, gain and offset words live in the store
	dcdp_chan_store #(
		.W        (W),
		.NCH      (NCH),
		.AW       (DCDP_CH_AW),
		.RST_IN   (RST_IN),
		.RST_GAIN (RST_GAIN),
		.RST_OFS  (RST_OFS)
	) u_store (
		.clk_sys       (clk_sys),
		.sys_rst       (sys_rst),
		.wr_en         (store_wr),
		.wr_word       (store_word),
		.wr_chan       (wr_chan),
		.wr_data       (wr_data),
		.calc_chan     (job_chan_r),
		.calc_first_r  (c_first),
		.calc_second_r (c_second),
		.calc_gain_r   (c_gain),
		.calc_offset_r (c_offset),
		.host_chan     (rd_chan),
		.host_word     (host_word),
		.host_data_r   (rd_data_r)
	);

	// [RL12] [RL19] multiply by gain+1, scale, add offset, remove half
	wire [W-1:0]          c_in    = job_bank_r ? c_second : c_first;
	wire [PW-1:0]         prod    = PW'(c_in) * PW'({1'b0, c_gain} + ONE_W1);
	wire signed [SW-1:0]  sum     = $signed({2'b00, prod[2*W:W]}) + $signed({3'b000, c_offset}) - HALF;
	// [RL21] clamp to code range
	wire                  under   = (sum < 0);
	wire                  over    = (sum > TOPVAL);
	wire [W-1:0]          clamped = under ? '0 : over ? TOPVAL[W-1:0] : sum[W-1:0];

	// [RL4] calibrated words have no host path
	logic [W-1:0] cal_first_r  [NCH];
	logic [W-1:0] cal_second_r [NCH];
	wire          calc_done = (state_r == DCDP_S_CALC);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r    <= DCDP_S_IDLE;
			job_chan_r <= '0;
			job_bank_r <= 1'b0;
		end else begin
			unique case (state_r)
				DCDP_S_IDLE: begin
					if (pick_any) begin
						job_chan_r <= pick_chan;
						job_bank_r <= pick_bank;
						state_r    <= DCDP_S_FETCH;
					end
				end
				DCDP_S_FETCH: state_r <= DCDP_S_CALC;
				DCDP_S_CALC:  state_r <= DCDP_S_IDLE;
			endcase
		end
	end

	// a fresh write in the clearing cycle keeps its job pending
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pend_first_r  <= '0;
			pend_second_r <= '0;
			calc_busy_r   <= 1'b0;
		end else begin
			pend_first_r  <= (pend_first_r & ~clr_first) | set_first;
			pend_second_r <= (pend_second_r & ~clr_second) | set_second;
			// busy covers the write cycle, so a poll right after a write sees it
			calc_busy_r   <= (state_r != DCDP_S_IDLE) || pick_any || store_wr;
		end
	end

	// calibrated words start at the input reset word
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				cal_first_r[i]  <= RST_IN;
				cal_second_r[i] <= RST_IN;
			end
		end else if (calc_done) begin
			if (job_bank_r) begin
				cal_second_r[job_chan_r] <= clamped;
			end else begin
				cal_first_r[job_chan_r] <= clamped;
			end
		end
	end

	// [RL6] [RL7] [RL9] group, control and setup registers
	logic [DCDP_GRP_CH-1:0] sel0_r;
	logic [DCDP_GRP_CH-1:0] sel1_r;
	wire [DCDP_GRP_CH-1:0]  sel_fill = {DCDP_GRP_CH{sel_all_value}};
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			group_zero_shift_r <= DCDP_RST_SHIFT;
			group_one_shift_r  <= DCDP_RST_SHIFT;
			control_bits_r     <= DCDP_RST_CTRL;
			monitor_setup_r    <= DCDP_RST_MON;
			gpio_setup_r       <= DCDP_RST_GPIO;
			sel0_r             <= DCDP_RST_SEL;
			sel1_r             <= DCDP_RST_SEL;
		end else begin
			if (wr_valid && wr_target == DCDP_T_SHIFT0) group_zero_shift_r <= wr_data[DCDP_SHIFT_W-1:0];
			if (wr_valid && wr_target == DCDP_T_SHIFT1) group_one_shift_r  <= wr_data[DCDP_SHIFT_W-1:0];
			if (wr_valid && wr_target == DCDP_T_CTRL)   control_bits_r     <= wr_data[DCDP_CTRL_W-1:0];
			if (wr_valid && wr_target == DCDP_T_MON)    monitor_setup_r    <= wr_data[DCDP_MON_W-1:0];
			if (wr_valid && wr_target == DCDP_T_GPIO)   gpio_setup_r       <= wr_data[DCDP_GPIO_W-1:0];
			// [RL17] global fill overrides a same-cycle select write
			if (sel_all_valid) begin
				sel0_r <= sel_fill;
				sel1_r <= sel_fill;
			end else begin
				if (wr_valid && wr_target == DCDP_T_SEL0) sel0_r <= wr_data[DCDP_GRP_CH-1:0];
				if (wr_valid && wr_target == DCDP_T_SEL1) sel1_r <= wr_data[DCDP_GRP_CH-1:0];
			end
		end
	end

	// acknowledge lines up with the registered store read data
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= rd_valid;
		end
	end

	// [RL1] [RL16] group select bit n drives channel n of the group
	wire [2*DCDP_GRP_CH-1:0] sel_all = {sel1_r, sel0_r};
	logic [W-1:0] routed [NCH];
	for (genvar gi = 0; gi < NCH; gi++) begin : g_route
		assign routed[gi] = sel_all[gi] ? cal_second_r[gi] : cal_first_r[gi];
	end
	logic load_now;
	assign load_now = ~load_s2_r;
	// [RL5] [RL18] [RL22] all converter registers load while pin low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				dac_code_r[i*W +: W] <= RST_IN;
			end
		end else if (load_now) begin
			for (int i = 0; i < NCH; i++) begin
				dac_code_r[i*W +: W] <= routed[i];
			end
		end
	end
endmodule
`default_nettype wire

// File: test/dcdp_data_path_assertions.sv
// port checker of the converter channel data path
`timescale 1ns/1ps
`default_nettype none
module dcdp_data_path_assertions #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic                                clk_sys,
	input wire logic                                sys_rst,
	// requests
	input wire logic                                wr_valid,
	input wire dcdp_pkg::dcdp_target_t              wr_target,
	input wire logic [W-1:0]                        wr_data,
	input wire logic                                load_outputs_n,
	// results
	input wire logic [dcdp_pkg::DCDP_NCH*W-1:0]     dac_code_r,
	input wire logic [dcdp_pkg::DCDP_SHIFT_W-1:0]   group_zero_shift_r,
	input wire logic [dcdp_pkg::DCDP_SHIFT_W-1:0]   group_one_shift_r,
	input wire logic [dcdp_pkg::DCDP_CTRL_W-1:0]    control_bits_r,
	input wire logic [dcdp_pkg::DCDP_MON_W-1:0]     monitor_setup_r,
	input wire logic                                calc_busy_r
);
	import dcdp_pkg::*;
	logic [DCDP_SHIFT_W-1:0] wd_sh;
	logic [DCDP_CTRL_W-1:0]  wd_ct;
	logic [DCDP_MON_W-1:0]   wd_mo;
	assign wd_sh = wr_data[DCDP_SHIFT_W-1:0];
	assign wd_ct = wr_data[DCDP_CTRL_W-1:0];
	assign wd_mo = wr_data[DCDP_MON_W-1:0];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_rst; $fell(sys_rst) |-> group_zero_shift_r == DCDP_RST_SHIFT
		&& group_one_shift_r == DCDP_RST_SHIFT && control_bits_r == DCDP_RST_CTRL; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_sh0; wr_valid && wr_target == DCDP_T_SHIFT0 |=> group_zero_shift_r == $past(wd_sh); endproperty
	a_sh0: assert property (p_sh0) else $error("group zero shift not written");
	property p_sh1; wr_valid && wr_target == DCDP_T_SHIFT1 |=> group_one_shift_r == $past(wd_sh); endproperty
	a_sh1: assert property (p_sh1) else $error("group one shift not written");
	property p_ctl; wr_valid && wr_target == DCDP_T_CTRL |=> control_bits_r == $past(wd_ct); endproperty
	a_ctl: assert property (p_ctl) else $error("control not written");
	property p_mon; wr_valid && wr_target == DCDP_T_MON |=> monitor_setup_r == $past(wd_mo); endproperty
	a_mon: assert property (p_mon) else $error("monitor setup not written");
	property p_busy; wr_valid && wr_target == DCDP_T_DATA |=> calc_busy_r; endproperty
	a_busy: assert property (p_busy) else $error("data write did not start recalculation");
	property p_job; $rose(calc_busy_r) |-> calc_busy_r[*3]; endproperty
	a_job: assert property (p_job) else $error("recalculation shorter than one job");
	property p_hold; load_outputs_n[*5] |-> $stable(dac_code_r); endproperty
	a_hold: assert property (p_hold) else $error("codes moved while load high");
endmodule
bind dcdp_data_path dcdp_data_path_assertions #(.W(W)) u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_target(wr_target),
	.wr_data(wr_data), .load_outputs_n(load_outputs_n), .dac_code_r(dac_code_r),
	.group_zero_shift_r(group_zero_shift_r), .group_one_shift_r(group_one_shift_r),
	.control_bits_r(control_bits_r), .monitor_setup_r(monitor_setup_r), .calc_busy_r(calc_busy_r));
`default_nettype wire

// File: test/dcdp_host_model.sv
// host side model: register writes, reads, select command and load pin
`timescale 1ns/1ps
`default_nettype none
module dcdp_host_model #(
	parameter int W = 16
) (
	// clock
	input  wire logic                           clk_sys,
	// requests
	output var logic                            wr_valid,
	output var dcdp_pkg::dcdp_target_t          wr_target,
	output var logic [dcdp_pkg::DCDP_CH_AW-1:0] wr_chan,
	output var logic [W-1:0]                    wr_data,
	output var logic                            rd_valid,
	output var dcdp_pkg::dcdp_target_t          rd_target,
	output var logic [dcdp_pkg::DCDP_CH_AW-1:0] rd_chan,
	output var logic                            sel_all_valid,
	output var logic                            sel_all_value,
	output var logic                            load_outputs_n,
	// answers
	input  wire logic [W-1:0]                   rd_data_r,
	input  wire logic                           rd_ack_r
);
	import dcdp_pkg::*;
	initial begin
		wr_valid = 1'b0;
		wr_target = DCDP_T_DATA;
		wr_chan = 4'h0;
		wr_data = '0;
		rd_valid = 1'b0;
		rd_target = DCDP_T_DATA;
		rd_chan = 4'h0;
		sel_all_valid = 1'b0;
		sel_all_value = 1'b0;
		load_outputs_n = 1'b1;
	end
	// idle data lines show the inverse, so a stale value never looks valid
	task automatic wr(input dcdp_target_t t, input logic [3:0] c, input logic [W-1:0] d);
		@(negedge clk_sys);
		wr_valid = 1'b1;
		wr_target = t;
		wr_chan = c;
		wr_data = d;
		@(negedge clk_sys);
		wr_valid = 1'b0;
		wr_chan = ~c;
		wr_data = ~d;
	endtask
	task automatic rd(input dcdp_target_t t, input logic [3:0] c, output logic [W-1:0] d, output logic ok);
		@(negedge clk_sys);
		rd_valid = 1'b1;
		rd_target = t;
		rd_chan = c;
		@(negedge clk_sys);
		rd_valid = 1'b0;
		ok = 1'b0;
		d = '0;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (rd_ack_r === 1'b1) begin
				ok = 1'b1;
				d = rd_data_r;
			end else
				@(negedge clk_sys);
		end
	endtask
	task automatic sel(input logic v);
		@(negedge clk_sys);
		sel_all_valid = 1'b1;
		sel_all_value = v;
		@(negedge clk_sys);
		sel_all_valid = 1'b0;
	endtask
	task automatic load(input logic v);
		@(negedge clk_sys);
		load_outputs_n = v;
	endtask
endmodule
`default_nettype wire

// File: test/dac_channel_data_path_tb.sv
// self-checking bench of the converter channel data path
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module dac_channel_data_path_tb;
	import dcdp_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic wr_valid, rd_valid, sel_all_valid, sel_all_value, load_outputs_n, rd_ack_r, calc_busy_r, bank, ok;
	dcdp_target_t wr_target, rd_target;
	logic [3:0] wr_chan, rd_chan, c;
	logic [15:0] wr_data, rd_data_r, rv, sel;
	logic [255:0] dac_code_r;
	logic [13:0] group_zero_shift_r, group_one_shift_r;
	logic [4:0] control_bits_r;
	logic [5:0] monitor_setup_r;
	logic [1:0] gpio_setup_r;
	logic [15:0] ia[16], ib[16], g[16], o[16], ca[16], cb[16];
	logic [31:0] seed = 32'hD978;
	logic [31:0] r;
	int n_fail = 0;
	int cmp_count = 0;
	dcdp_target_t tl[8] = '{DCDP_T_DATA, DCDP_T_DATA, DCDP_T_GAIN, DCDP_T_OFFSET, DCDP_T_CTRL,
		DCDP_T_SEL0, DCDP_T_SEL1, DCDP_T_DATA};
	always #50 clk_sys = ~clk_sys;
	dcdp_data_path #(.W(16)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_valid(wr_valid),
		.wr_target(wr_target), .wr_chan(wr_chan), .wr_data(wr_data), .rd_valid(rd_valid),
		.rd_target(rd_target), .rd_chan(rd_chan), .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r),
		.sel_all_valid(sel_all_valid), .sel_all_value(sel_all_value), .load_outputs_n(load_outputs_n),
		.dac_code_r(dac_code_r), .group_zero_shift_r(group_zero_shift_r),
		.group_one_shift_r(group_one_shift_r), .control_bits_r(control_bits_r),
		.monitor_setup_r(monitor_setup_r), .gpio_setup_r(gpio_setup_r), .calc_busy_r(calc_busy_r));
	dcdp_host_model #(.W(16)) host (.clk_sys(clk_sys), .wr_valid(wr_valid), .wr_target(wr_target),
		.wr_chan(wr_chan), .wr_data(wr_data), .rd_valid(rd_valid), .rd_target(rd_target),
		.rd_chan(rd_chan), .sel_all_valid(sel_all_valid), .sel_all_value(sel_all_value),
		.load_outputs_n(load_outputs_n), .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// results outside the code range are clamped, not wrapped
	function automatic logic [15:0] calc(input logic [15:0] x, input logic [15:0] m, input logic [15:0] k);
		longint v;
		v = ((longint'(x) * (longint'(m) + 1)) >>> 16) + longint'(k) - 32768;
		if (v < 0)
			return 16'h0000;
		if (v > 65535)
			return 16'hFFFF;
		return v[15:0];
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// a bank change waits for queued jobs, which read their words only when they run
	task automatic put(input dcdp_target_t t, input logic [3:0] ch, input logic [15:0] d);
		if (t == DCDP_T_CTRL)
			settle();
		host.wr(t, ch, d);
		if (t == DCDP_T_DATA && bank) ib[ch] = d;
		if (t == DCDP_T_DATA && !bank) ia[ch] = d;
		if (t == DCDP_T_GAIN) g[ch] = d;
		if (t == DCDP_T_OFFSET) o[ch] = d;
		if (t == DCDP_T_CTRL) bank = d[0];
		if (t == DCDP_T_SEL0) sel[7:0] = d[7:0];
		if (t == DCDP_T_SEL1) sel[15:8] = d[7:0];
		if (t <= DCDP_T_OFFSET && bank) cb[ch] = calc(ib[ch], g[ch], o[ch]);
		if (t <= DCDP_T_OFFSET && !bank) ca[ch] = calc(ia[ch], g[ch], o[ch]);
	endtask
	task automatic settle();
		for (int i = 0; i <= 400; i++) begin
			@(negedge clk_sys);
			if (calc_busy_r === 1'b0)
				return;
		end
		n_fail++;
		$display("[FAIL] %0t recalculation never finished", $time);
		end_of_test();
	endtask
	task automatic chk_dac();
		host.load(1'b0);
		repeat (4) @(negedge clk_sys);
		for (int i = 0; i < 16; i++)
			`CHK(dac_code_r[i*16 +: 16], sel[i] ? cb[i] : ca[i])
		host.load(1'b1);
	endtask
	task automatic reset_dut(input int n);
		bank = 1'b0;
		sel = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			{ia[i], ib[i], o[i], ca[i], cb[i]} = {5{16'h8000}};
			g[i] = 16'hFFFF;
		end
		sys_rst = 1'b1;
		repeat (n) @(negedge clk_sys);
		sys_rst = 1'b0;
	endtask
	initial begin
		reset_dut(10);
		`CHK({group_zero_shift_r, group_one_shift_r}, {2{DCDP_RST_SHIFT}})
		`CHK({control_bits_r, monitor_setup_r, gpio_setup_r}, 13'h0000)
		host.rd(DCDP_T_GAIN, 4'h5, rv, ok);
		`CHK({ok, rv}, {1'b1, 16'hFFFF})
		host.rd(DCDP_T_DATA_B, 4'hC, rv, ok);
		`CHK({ok, rv}, {1'b1, 16'h8000})
		chk_dac();
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			host.wr(DCDP_T_SHIFT0, 4'h0, r[15:0]);
			`CHK(group_zero_shift_r, r[13:0])
			host.wr(DCDP_T_SHIFT1, 4'h0, r[31:16]);
			`CHK(group_one_shift_r, r[29:16])
			host.wr(DCDP_T_MON, 4'h0, r[15:0]);
			host.wr(DCDP_T_GPIO, 4'h0, r[31:16]);
			`CHK({monitor_setup_r, gpio_setup_r}, {r[5:0], r[17:16]})
			put(DCDP_T_CTRL, 4'h0, r[15:0]);
			`CHK(control_bits_r, r[4:0])
		end
		$display("test registers done");
		reset_dut(3);
		`CHK({group_zero_shift_r, group_one_shift_r}, {2{DCDP_RST_SHIFT}})
		`CHK(control_bits_r, DCDP_RST_CTRL)
		host.rd(DCDP_T_OFFSET, 4'h3, rv, ok);
		`CHK({ok, rv}, {1'b1, 16'h8000})
		$display("test mid-run reset done");
		// gains and offsets leave the safe range on purpose to reach the clamp
		for (int k = 0; k < 12; k++) begin
			for (int j = 0; j < 8; j++) begin
				r = rnd();
				put(tl[r[31:29]], r[19:16], r[15:0]);
			end
			if (k == 5 || k == 8) begin
				host.sel(k == 5);
				sel = {16{k == 5}};
			end
			settle();
			c = r[23:20];
			host.rd(DCDP_T_DATA, c, rv, ok);
			`CHK({ok, rv}, {1'b1, bank ? ib[c] : ia[c]})
			host.rd(DCDP_T_DATA_B, c, rv, ok);
			`CHK({ok, rv}, {1'b1, ib[c]})
			chk_dac();
		end
		$display("test calibration done");
		host.sel(1'b0);
		sel = 16'h0000;
		host.load(1'b0);
		put(DCDP_T_CTRL, 4'h0, 16'h0000);
		put(DCDP_T_DATA, 4'hF, 16'hFFFF);
		put(DCDP_T_GAIN, 4'hF, 16'hFFFF);
		put(DCDP_T_OFFSET, 4'hF, 16'hFFFF);
		settle();
		repeat (4) @(negedge clk_sys);
		`CHK(dac_code_r[255:240], 16'hFFFF)
		host.load(1'b1);
		repeat (3) @(negedge clk_sys);
		put(DCDP_T_OFFSET, 4'hF, 16'h0000); // result stays in range
		settle();
		repeat (4) @(negedge clk_sys);
		`CHK(dac_code_r[255:240], 16'hFFFF)
		chk_dac();
		$display("test load done");
		end_of_test();
	end
endmodule
`default_nettype wire
